// File: hdl/crf_regfile.sv
// Processor register file: program-flow, stack pointer, flags, constants, R4..R15.
// Assumes a single-cycle command interface from the decode/execute datapath;
// memory traffic for the stack is done outside, this block supplies addresses/data.
`timescale 1ns/1ps
`default_nettype none

module crf_regfile
    import crf_pkg::*;
#(
    parameter int unsigned NGEN = 12
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Source read port
    input  wire logic [3:0]    src_sel_i,
    input  wire logic [1:0]    src_mode_field_i,
    input  wire crf_width_t    src_width_i,
    output logic [19:0]        src_data_o,
    output logic               src_is_const_o,
    // Second read port (destination operand)
    input  wire logic [3:0]    dst_sel_i,
    output logic [19:0]        dst_data_o,
    // Writes, flags, flow
    input  wire crf_wr_t       wr_i,
    input  wire crf_flag_req_t flag_i,
    input  wire crf_flow_t     flow_i,
    // Stack interface
    output logic [19:0]        stack_addr_o,
    output logic [19:0]        stack_wdata_o,
    output logic [15:0]        stack_sr_word_o,
    // State
    output logic [19:0]        program_flow_o,
    output logic [19:0]        stack_ptr_o,
    output logic [15:0]        flags_o,
    output logic               global_irq_enable_o,
    output logic               processor_halt_o,
    output logic               crystal_off_o,
    output logic               loop_ctrl_off_o,
    output logic               dco_off_o
);

    // Elaboration-time guard: the register map only has room for twelve general registers
    if (NGEN != 12) begin : gen_ngen_check
        $error("crf_regfile: NGEN must be 12");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [19:0]            program_flow;
        logic [19:0]            stack_ptr;
        logic [15:0]            flags;
        logic [11:0][19:0]      gen;
        logic [19:0]            stack_addr;
        logic [19:0]            stack_wdata;
        logic [15:0]            stack_sr_word;
    } crf_state_t;

    crf_state_t state_reg;
    crf_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Width-dependent write shaping; sign extend is the lone exception
    function automatic logic [19:0] crf_shape(input logic [19:0] d, input crf_width_t w, input logic sx);
        logic [19:0] r;
        r = d;
        if (sx) begin
            r = {{12{d[7]}}, d[7:0]};
        end else if (w == CRF_W_BYTE) begin
            r = {12'h000, d[7:0]};
        end else if (w == CRF_W_WORD) begin
            r = {4'h0, d[15:0]};
        end
        return r;
    endfunction

    // Plain register read, no width masking
    function automatic logic [19:0] crf_read(input crf_state_t s, input logic [3:0] sel);
        logic [19:0] r;
        r = CRF_K0;
        if (sel == CRF_R_PC) begin
            r = s.program_flow;
        end else if (sel == CRF_R_SP) begin
            r = s.stack_ptr;
        end else if (sel == CRF_R_SR) begin
            r = {4'h0, s.flags};
        end else if (sel == CRF_R_CG) begin
            r = CRF_K0;
        end else begin
            r = s.gen[sel - 4'h4];
        end
        return r;
    endfunction

    // Sign of a value at the given width
    function automatic logic crf_msb(input logic [19:0] d, input crf_width_t w);
        logic r;
        r = d[19];
        if (w == CRF_W_BYTE) begin
            r = d[7];
        end else if (w == CRF_W_WORD) begin
            r = d[15];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Source port with constant generators

    always_comb begin
        src_is_const_o = 1'b0;
        src_data_o     = crf_read(state_reg, src_sel_i);
        if (src_sel_i == CRF_R_SR && src_mode_field_i != CRF_AS_REG) begin
            src_is_const_o = 1'b1;
            if (src_mode_field_i == CRF_AS_IDX) begin
                src_data_o = CRF_K0;
            end else if (src_mode_field_i == CRF_AS_IND) begin
                src_data_o = CRF_K4;
            end else begin
                src_data_o = CRF_K8;
            end
        end else if (src_sel_i == CRF_R_CG) begin
            src_is_const_o = 1'b1;
            if (src_mode_field_i == CRF_AS_REG) begin
                src_data_o = CRF_K0;
            end else if (src_mode_field_i == CRF_AS_IDX) begin
                src_data_o = CRF_K1;
            end else if (src_mode_field_i == CRF_AS_IND) begin
                src_data_o = CRF_K2;
            end else if (src_width_i == CRF_W_BYTE) begin
                src_data_o = CRF_KB;
            end else if (src_width_i == CRF_W_WORD) begin
                src_data_o = CRF_KW;
            end else begin
                src_data_o = CRF_KA;
            end
        end
        dst_data_o = crf_read(state_reg, dst_sel_i);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [19:0] pf;
        logic [19:0] sp;
        logic [15:0] fl;
        logic [19:0] wv;
        logic        sa;
        logic        sb;
        logic        sr;
        logic [19:0] rmask;
        state_next = state_reg;
        pf    = state_reg.program_flow;
        sp    = state_reg.stack_ptr;
        fl    = state_reg.flags;
        wv    = crf_shape(wr_i.data, wr_i.width, wr_i.sign_extend_op);
        sa    = crf_msb(flag_i.a, flag_i.width);
        sb    = crf_msb(flag_i.b, flag_i.width);
        sr    = crf_msb(flag_i.res, flag_i.width);
        rmask = (flag_i.width == CRF_W_BYTE) ? CRF_KB :
                (flag_i.width == CRF_W_WORD) ? CRF_KW : CRF_KA;

        // Sequential advance past the instruction just fetched
        if (flow_i.adv) begin
            pf = pf + {17'h00000, flow_i.len_words, 1'b0} + CRF_STEP_W;
        end

        // Flow and stack commands
        case (flow_i.op)
            CRF_OP_PUSHW: begin
                sp = state_reg.stack_ptr - CRF_STEP_W;
                state_next.stack_wdata = {4'h0, pf[15:0]};
            end
            CRF_OP_PUSHA: begin
                sp = state_reg.stack_ptr - CRF_STEP_A;
                state_next.stack_wdata = pf;
            end
            CRF_OP_IRQ: begin
                sp = state_reg.stack_ptr - CRF_STEP_A;
                state_next.stack_wdata   = pf;
                state_next.stack_sr_word = fl;
                state_next.stack_sr_word[CRF_B_PCHI +: 4] = pf[19:16];
            end
            CRF_OP_POPW: begin
                pf = {4'h0, flow_i.target[15:0]};
                sp = state_reg.stack_ptr + CRF_STEP_W;
            end
            CRF_OP_POPA: begin
                pf = flow_i.target;
                sp = state_reg.stack_ptr + CRF_STEP_A;
            end
            CRF_OP_BRS: begin
                pf = {4'h0, flow_i.target[15:0]};
            end
            CRF_OP_BRL: begin
                pf = flow_i.target;
            end
            CRF_OP_RETI: begin
                pf = {flow_i.popped_sr[CRF_B_PCHI +: 4], flow_i.target[15:0]};
                fl = flow_i.popped_sr & 16'h0FFF;
                sp = state_reg.stack_ptr + CRF_STEP_A;
            end
            default: begin
            end
        endcase
        state_next.stack_addr = sp;

        // Flag update from the execute unit
        if (flag_i.en) begin
            fl[CRF_B_C] = flag_i.carry;
            fl[CRF_B_Z] = ((flag_i.res & rmask) == CRF_K0);
            fl[CRF_B_N] = sr;
            if (flag_i.is_sub) begin
                fl[CRF_B_V] = (sa != sb) && (sr != sa);
            end else begin
                fl[CRF_B_V] = (sa == sb) && (sr != sa);
            end
        end

        // Explicit destination write wins over flow, stack and flags
        if (wr_i.en) begin
            if (wr_i.dst == CRF_R_PC) begin
                pf = wv;
            end else if (wr_i.dst == CRF_R_SP) begin
                sp = wv;
            end else if (wr_i.dst == CRF_R_SR) begin
                fl = wv[15:0];                                    // 20-bit writes not guarded
            end else if (wr_i.dst == CRF_R_CG) begin
                fl = fl;                                          // constant source, no storage
            end else begin
                state_next.gen[wr_i.dst - 4'h4] = wv;
            end
        end

        state_next.program_flow = {pf[19:1], 1'b0};
        state_next.stack_ptr    = {sp[19:1], 1'b0};
        state_next.flags        = fl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from state

    assign program_flow_o      = state_reg.program_flow;
    assign stack_ptr_o         = state_reg.stack_ptr;
    assign flags_o             = state_reg.flags;
    assign stack_addr_o        = state_reg.stack_addr;
    assign stack_wdata_o       = state_reg.stack_wdata;
    assign stack_sr_word_o     = state_reg.stack_sr_word;
    assign global_irq_enable_o = state_reg.flags[CRF_B_GIE];
    assign processor_halt_o    = state_reg.flags[CRF_B_HALT];
    assign crystal_off_o       = state_reg.flags[CRF_B_XTOFF];
    assign loop_ctrl_off_o     = state_reg.flags[CRF_B_LOOPOF];
    assign dco_off_o           = state_reg.flags[CRF_B_DCOOFF];

endmodule

`default_nettype wire

// File: inc/crf_pkg.sv
// Constants, types and command codes for the 20-bit processor register file.
// Assumes the decode/execute datapath drives one command per cycle on clk_i.
package crf_pkg;

    localparam int unsigned CRF_AW    = 20;
    localparam int unsigned CRF_NREG  = 16;
    localparam logic [3:0]  CRF_R_PC  = 4'h0;
    localparam logic [3:0]  CRF_R_SP  = 4'h1;
    localparam logic [3:0]  CRF_R_SR  = 4'h2;
    localparam logic [3:0]  CRF_R_CG  = 4'h3;

    // Flags register bit positions
    localparam int unsigned CRF_B_C      = 0;
    localparam int unsigned CRF_B_Z      = 1;
    localparam int unsigned CRF_B_N      = 2;
    localparam int unsigned CRF_B_GIE    = 3;
    localparam int unsigned CRF_B_HALT   = 4;
    localparam int unsigned CRF_B_XTOFF  = 5;
    localparam int unsigned CRF_B_LOOPOF = 6;
    localparam int unsigned CRF_B_DCOOFF = 7;
    localparam int unsigned CRF_B_V      = 8;
    localparam int unsigned CRF_B_PCHI   = 12;   // Stacked flags word carries program-flow 19:16 here

    // Source addressing modes
    localparam logic [1:0] CRF_AS_REG = 2'h0;
    localparam logic [1:0] CRF_AS_IDX = 2'h1;
    localparam logic [1:0] CRF_AS_IND = 2'h2;
    localparam logic [1:0] CRF_AS_INC = 2'h3;

    // Constant values
    localparam logic [19:0] CRF_K0   = 20'h00000;
    localparam logic [19:0] CRF_K1   = 20'h00001;
    localparam logic [19:0] CRF_K2   = 20'h00002;
    localparam logic [19:0] CRF_K4   = 20'h00004;
    localparam logic [19:0] CRF_K8   = 20'h00008;
    localparam logic [19:0] CRF_KB   = 20'h000FF;
    localparam logic [19:0] CRF_KW   = 20'h0FFFF;
    localparam logic [19:0] CRF_KA   = 20'hFFFFF;
    localparam logic [19:0] CRF_STEP_W = 20'h00002;
    localparam logic [19:0] CRF_STEP_A = 20'h00004;
    localparam logic [19:0] CRF_RST  = 20'h00000;
    localparam logic [15:0] CRF_SR_RST = 16'h0000;

    typedef enum logic [1:0] {
        CRF_W_BYTE = 2'h0,
        CRF_W_WORD = 2'h1,
        CRF_W_ADDR = 2'h2
    } crf_width_t;

    // Stack and flow commands, one-hot
    typedef enum logic [7:0] {
        CRF_OP_NONE  = 8'h00,
        CRF_OP_PUSHW = 8'h01,   // Word push, also short call
        CRF_OP_PUSHA = 8'h02,   // Address-word push, also long call
        CRF_OP_POPW  = 8'h04,   // Short return / word pop
        CRF_OP_POPA  = 8'h08,   // Long return / address pop
        CRF_OP_BRS   = 8'h10,   // Short branch or short call target
        CRF_OP_BRL   = 8'h20,   // Long branch or long call target
        CRF_OP_IRQ   = 8'h40,   // Interrupt entry, one push of 4 bytes total
        CRF_OP_RETI  = 8'h80    // Interrupt return
    } crf_op_t;

    // Flag update request from the execute unit
    typedef struct packed {
        logic       en;
        logic       is_sub;     // Subtract/compare sense for overflow
        crf_width_t width;
        logic [19:0] a;         // Destination operand
        logic [19:0] b;         // Source operand
        logic [19:0] res;
        logic       carry;
    } crf_flag_req_t;

    // Explicit register write
    typedef struct packed {
        logic       en;
        logic [3:0] dst;
        crf_width_t width;
        logic       sign_extend_op;
        logic [19:0] data;
    } crf_wr_t;

    // Program-flow control
    typedef struct packed {
        crf_op_t     op;
        logic        adv;       // Advance past fetched instruction
        logic [1:0]  len_words; // 0..3 => 2, 4, 6, 8 bytes
        logic [19:0] target;    // Branch target or popped data
        logic [15:0] popped_sr; // Stacked flags word on interrupt return
    } crf_flow_t;

endpackage

// File: test/crf_exec_model.sv
// Execute-unit model: turns an add or subtract into a flag update request.
// Assumes the bench drives its operands at the clock edge; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module crf_exec_model
    import crf_pkg::*;
(
    input  wire logic        go_i,
    input  wire logic        sub_i,
    input  wire crf_width_t  width_i,
    input  wire logic [19:0] a_i,
    input  wire logic [19:0] b_i,
    output var crf_flag_req_t flag_o
);
    logic [20:0] sum;
    logic [19:0] msk;
    logic [4:0]  top;
    ////////////////////////////////////////////////////////////
    // Arithmetic at operand width; subtract is a plus not-b plus one
    always_comb begin
        top = (width_i == CRF_W_BYTE) ? 5'h08 : (width_i == CRF_W_WORD) ? 5'h10 : 5'h14;
        msk = (top == 5'h14) ? 20'hFFFFF : ((20'h00001 << top) - 20'h00001);
        sum = {1'b0, a_i & msk} + {1'b0, (sub_i ? ~b_i : b_i) & msk} + {20'h00000, sub_i};
        // Flags are only ever fed as requests, never as a wide write
        flag_o = '{go_i, sub_i, width_i, a_i, b_i, sum[19:0] & msk, sum[top]};
    end
endmodule
`default_nettype wire

// File: test/crf_regfile_asserts.sv
// Checker for the register file: stack steps, flow, constants, flags.
// Assumes it is bound to crf_regfile and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module crf_regfile_asserts
    import crf_pkg::*;
#(
    parameter int unsigned NGEN = 12
) (
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic [3:0]    src_sel_i,
    input wire logic [1:0]    src_mode_field_i,
    input wire crf_width_t    src_width_i,
    input wire logic [19:0]   src_data_o,
    input wire logic          src_is_const_o,
    input wire logic [3:0]    dst_sel_i,
    input wire logic [19:0]   dst_data_o,
    input wire crf_wr_t       wr_i,
    input wire crf_flag_req_t flag_i,
    input wire crf_flow_t     flow_i,
    input wire logic [19:0]   stack_addr_o,
    input wire logic [19:0]   stack_wdata_o,
    input wire logic [15:0]   stack_sr_word_o,
    input wire logic [19:0]   program_flow_o,
    input wire logic [19:0]   stack_ptr_o,
    input wire logic [15:0]   flags_o,
    input wire logic          global_irq_enable_o,
    input wire logic          processor_halt_o,
    input wire logic          crystal_off_o,
    input wire logic          loop_ctrl_off_o,
    input wire logic          dco_off_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    // Explicit writes win, so stack and flow checks step aside for them
    wire logic sp_wr = wr_i.en && wr_i.dst == CRF_R_SP;
    wire logic pf_wr = wr_i.en && wr_i.dst == CRF_R_PC;
    wire logic sr_wr = wr_i.en && wr_i.dst == CRF_R_SR;
    sequence s_byte_wr;
        wr_i.en && wr_i.dst > 4'h3 && wr_i.width == CRF_W_BYTE && !wr_i.sign_extend_op;
    endsequence
    sequence s_pop_long;
        flow_i.op == CRF_OP_POPA && !sp_wr && !pf_wr;
    endsequence
    ////////////////////////////////////////////////////////////
    a_pf_even: assert property (program_flow_o[0] == 1'b0)
        else $error("program flow odd");
    a_sp_even: assert property (stack_ptr_o[0] == 1'b0)
        else $error("stack pointer odd");
    a_cg_four: assert property (src_sel_i == CRF_R_SR && src_mode_field_i == 2'h2 |-> src_data_o == CRF_K4 && src_is_const_o)
        else $error("constant four wrong");
    a_cg_ones: assert property (src_sel_i == CRF_R_CG && src_mode_field_i == 2'h3 && src_width_i == CRF_W_WORD |-> src_data_o == CRF_KW)
        else $error("word all ones wrong");
    a_push_word: assert property (flow_i.op == CRF_OP_PUSHW && !sp_wr |=> stack_ptr_o == $past(stack_ptr_o) - 20'h00002 && stack_wdata_o[19:16] == 4'h0)
        else $error("word push wrong");
    a_long_ret: assert property (s_pop_long |=> program_flow_o == $past(flow_i.target) && stack_ptr_o == $past(stack_ptr_o) + 20'h00004)
        else $error("long return wrong");
    a_short_ret: assert property (flow_i.op == CRF_OP_POPW && !sp_wr && !pf_wr |=> stack_ptr_o == $past(stack_ptr_o) + 20'h00002)
        else $error("short return step wrong");
    a_short_br: assert property (flow_i.op == CRF_OP_BRS && !pf_wr |=> program_flow_o == {4'h0, $past(flow_i.target[15:0])})
        else $error("short branch top bits");
    a_pop_sp: assert property (sp_wr && wr_i.width == CRF_W_ADDR |=> stack_ptr_o == $past(wr_i.data))
        else $error("stack write lost");
    a_byte_clear: assert property (s_byte_wr ##1 dst_sel_i == $past(wr_i.dst) |-> dst_data_o[19:8] == 12'h000)
        else $error("byte write kept high bits");
    a_flag_bits: assert property ({dco_off_o, loop_ctrl_off_o, crystal_off_o, processor_halt_o, global_irq_enable_o} == flags_o[7:3])
        else $error("control bits differ from flags");
    a_zero_flag: assert property (flag_i.en && flag_i.width == CRF_W_WORD && !sr_wr && flow_i.op == CRF_OP_NONE |=> flags_o[CRF_B_Z] == ($past(flag_i.res[15:0]) == 16'h0000))
        else $error("zero flag wrong");
endmodule
bind crf_regfile crf_regfile_asserts #(.NGEN(NGEN)) chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_sel_i(src_sel_i),
    .src_mode_field_i(src_mode_field_i), .src_width_i(src_width_i), .src_data_o(src_data_o),
    .src_is_const_o(src_is_const_o), .dst_sel_i(dst_sel_i), .dst_data_o(dst_data_o), .wr_i(wr_i), .flag_i(flag_i),
    .flow_i(flow_i), .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o), .stack_sr_word_o(stack_sr_word_o),
    .program_flow_o(program_flow_o), .stack_ptr_o(stack_ptr_o), .flags_o(flags_o),
    .global_irq_enable_o(global_irq_enable_o), .processor_halt_o(processor_halt_o), .crystal_off_o(crystal_off_o),
    .loop_ctrl_off_o(loop_ctrl_off_o), .dco_off_o(dco_off_o));
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the register file, with the execute-unit model.
// Assumes a 40 MHz clock and one command per task call.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import crf_pkg::*;
    logic clk_i, rst_n_i, src_is_const_o, go, sub, global_irq_enable, halt, xoff, loff, doff;
    logic [3:0] src_sel_i, dst_sel_i;
    logic [1:0] src_mode_field_i;
    crf_width_t src_width_i, fw;
    crf_wr_t wr_i;
    crf_flow_t flow_i;
    crf_flag_req_t flag_i;
    logic [19:0] src_data_o, dst_data_o, sa, swd, pf, sp, fa, fb, e;
    logic [15:0] ssr, flags_o;
    int err_count, checks;
    crf_regfile dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_sel_i(src_sel_i), .src_mode_field_i(src_mode_field_i),
        .src_width_i(src_width_i), .src_data_o(src_data_o), .src_is_const_o(src_is_const_o), .dst_sel_i(dst_sel_i),
        .dst_data_o(dst_data_o), .wr_i(wr_i), .flag_i(flag_i), .flow_i(flow_i), .stack_addr_o(sa),
        .stack_wdata_o(swd), .stack_sr_word_o(ssr), .program_flow_o(pf), .stack_ptr_o(sp), .flags_o(flags_o),
        .global_irq_enable_o(global_irq_enable), .processor_halt_o(halt), .crystal_off_o(xoff), .loop_ctrl_off_o(loff),
        .dco_off_o(doff));
    crf_exec_model exec_u (.go_i(go), .sub_i(sub), .width_i(fw), .a_i(fa), .b_i(fb), .flag_o(flag_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Each write, flow or flag access drives after an edge, holds one cycle, settles 1 ns; reads only settle 1 ns
    task automatic wreg(input logic [3:0] d, input crf_width_t w, input logic [19:0] v, input logic s);
        @(posedge clk_i);
        wr_i <= '{1'b1, d, w, s, v};
        @(posedge clk_i);
        wr_i <= '0;
        #1;
    endtask
    task automatic fl(input crf_op_t op, input logic [19:0] t, input logic ad, input logic [1:0] n,
                      input logic [15:0] r);
        @(posedge clk_i);
        flow_i <= '{op, ad, n, t, r};
        @(posedge clk_i);
        flow_i <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] r, input logic [1:0] m, input crf_width_t w, input logic [19:0] x,
                      input logic k);
        @(posedge clk_i);
        src_sel_i <= r;
        src_mode_field_i <= m;
        src_width_i <= w;
        #1;
        chk(src_data_o, x);
        chk({19'h00000, src_is_const_o}, {19'h00000, k});
    endtask
    task automatic flg(input logic s, input crf_width_t w, input logic [19:0] a, input logic [19:0] b,
                       input logic [15:0] x);
        @(posedge clk_i);
        {go, sub, fa, fb} <= {1'b1, s, a, b};
        fw <= w;
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        chk({4'h0, flags_o & 16'h0107}, {4'h0, x});
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        summarize;
    end
    initial begin
        {rst_n_i, go, sub, src_sel_i, dst_sel_i, src_mode_field_i, fa, fb} = '0;
        {wr_i, flow_i} = '0;
        src_width_i = CRF_W_BYTE;
        fw = CRF_W_BYTE;
        dst_sel_i = 4'h4;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(pf | sp | {4'h0, flags_o}, 20'h00000);
        rd(CRF_R_SR, 2'h1, CRF_W_WORD, CRF_K0, 1'b1);
        rd(CRF_R_SR, 2'h2, CRF_W_WORD, 20'h00004, 1'b1);
        rd(CRF_R_SR, 2'h3, CRF_W_WORD, 20'h00008, 1'b1);
        for (int m = 0; m < 3; m++) rd(CRF_R_CG, m[1:0], CRF_W_WORD, m[19:0], 1'b1);
        rd(CRF_R_CG, 2'h3, CRF_W_BYTE, 20'h000FF, 1'b1);
        rd(CRF_R_CG, 2'h3, CRF_W_WORD, 20'h0FFFF, 1'b1);
        rd(CRF_R_CG, 2'h3, CRF_W_ADDR, 20'hFFFFF, 1'b1);
        wreg(CRF_R_CG, CRF_W_WORD, 20'h01234, 1'b0);
        rd(CRF_R_CG, 2'h0, CRF_W_WORD, 20'h00000, 1'b1);
        // Control bits set through a word write only
        wreg(CRF_R_SR, CRF_W_WORD, 20'h000F8, 1'b0);
        rd(CRF_R_SR, 2'h0, CRF_W_WORD, 20'h000F8, 1'b0);
        chk({15'h0, doff, loff, xoff, halt, global_irq_enable}, 20'h0001F);
        wreg(CRF_R_SR, CRF_W_WORD, 20'h00000, 1'b0);
        chk({15'h0, doff, loff, xoff, halt, global_irq_enable}, 20'h00000);
        wreg(4'h4, CRF_W_ADDR, 20'hABCDE, 1'b0);
        chk(dst_data_o, 20'hABCDE);
        wreg(4'h4, CRF_W_WORD, 20'hFFFFF, 1'b0);
        chk(dst_data_o, 20'h0FFFF);
        wreg(4'h4, CRF_W_BYTE, 20'h12385, 1'b0);
        chk(dst_data_o, 20'h00085);
        wreg(4'h4, CRF_W_ADDR, 20'h00085, 1'b1);
        chk(dst_data_o, 20'hFFF85);
        wreg(CRF_R_PC, CRF_W_WORD, 20'h5A3C6, 1'b0);
        chk(pf, 20'h0A3C6);
        wreg(CRF_R_PC, CRF_W_ADDR, 20'h5A3C6, 1'b0);
        chk(pf, 20'h5A3C6);
        wreg(CRF_R_SP, CRF_W_ADDR, 20'h02400, 1'b0);
        fl(CRF_OP_PUSHW, 20'h00000, 1'b0, 2'h0, 16'h0000);
        chk(sp, 20'h023FE);
        chk(sa, 20'h023FE);
        chk(swd, 20'h0A3C6);
        fl(CRF_OP_PUSHA, 20'h00000, 1'b0, 2'h0, 16'h0000);
        chk(sp, 20'h023FA);
        chk(swd, 20'h5A3C6);
        fl(CRF_OP_POPA, 20'h7BCD0, 1'b0, 2'h0, 16'h0000);
        chk(pf, 20'h7BCD0);
        chk(sp, 20'h023FE);
        fl(CRF_OP_POPW, 20'h01234, 1'b0, 2'h0, 16'h0000);
        chk({4'h0, pf[15:0]}, 20'h01234);
        chk(sp, 20'h02400);
        fl(CRF_OP_BRS, 20'h3F002, 1'b0, 2'h0, 16'h0000);
        chk(pf, 20'h0F002);
        fl(CRF_OP_BRL, 20'h3F002, 1'b0, 2'h0, 16'h0000);
        chk(pf, 20'h3F002);
        e = 20'h3F002;
        for (int n = 0; n < 4; n++) begin
            fl(CRF_OP_NONE, 20'h00000, 1'b1, n[1:0], 16'h0000);
            e = e + 20'(2 * (n + 1));
            chk(pf, e);
        end
        fl(CRF_OP_IRQ, 20'h0C000, 1'b0, 2'h0, 16'h0000);
        chk({16'h0000, ssr[15:12]}, 20'h00003);
        chk({4'h0, ssr}, 20'h03000);
        chk(sp, 20'h023FC);
        fl(CRF_OP_RETI, 20'h0F016, 1'b0, 2'h0, 16'h3005);
        chk(pf, 20'h3F016);
        chk({4'h0, flags_o}, 20'h00005);
        // Pop into the stack pointer: the popped value wins over the step
        @(posedge clk_i);
        wr_i <= '{1'b1, CRF_R_SP, CRF_W_ADDR, 1'b0, 20'h02222};
        flow_i <= '{CRF_OP_POPW, 1'b0, 2'h0, 20'h00100, 16'h0000};
        @(posedge clk_i);
        {wr_i, flow_i} <= '0;
        #1;
        chk(sp, 20'h02222);
        flg(1'b0, CRF_W_WORD, 20'h07FFF, 20'h00001, 16'h0104);
        flg(1'b0, CRF_W_WORD, 20'h0FFFF, 20'h00001, 16'h0003);
        flg(1'b1, CRF_W_WORD, 20'h08000, 20'h00001, 16'h0101);
        flg(1'b1, CRF_W_WORD, 20'h00001, 20'h08000, 16'h0104);
        flg(1'b1, CRF_W_WORD, 20'h00005, 20'h00003, 16'h0001);
        flg(1'b0, CRF_W_BYTE, 20'h0007F, 20'h00001, 16'h0104);
        flg(1'b0, CRF_W_ADDR, 20'h7FFFF, 20'h00001, 16'h0104);
        summarize;
    end
endmodule
`default_nettype wire
